// file: verilog/mgmt_status_regs.vh
`ifndef MGMT_STATUS_REGS_VH
`define MGMT_STATUS_REGS_VH

// Clock rate and timing figures
`define CLK_MHZ 125
`define T_INIT_MS 2000
`define T_RESET_MIN_US 2
// 2 us and 2000 ms in clock cycles, sized to their counters
`define RST_MIN_CYC 9'h0fa
`define INIT_CYC 28'hee6b280

// Two-wire bus slave address and byte framing
`define DEV_ADDR 7'h50
`define BYTE_BITS 4'h8

// Lower map byte addresses
`define A_STATUS2 8'h02
`define A_FLAG_FIRST 8'h03
`define A_FLAG_LAST 8'h15
`define A_LOS_FLAG 8'h03
`define A_FAULT_FLAG 8'h04
`define A_OTHER_FLAG 8'h06
`define A_CTRL_PDOWN 8'h5d
`define A_MASK_FIRST 8'h64
`define A_MASK_LAST 8'h6a

// Field positions
`define DNR_BIT 0
`define PDOWN_BIT 1
`define MASK_LOS 3'h0
`define MASK_FAULT 3'h1
`define MASK_OTHER 3'h2
`define MASK_BYTES 7

`endif

// file: verilog/sync2.v
`timescale 1ns/1ps
// Two-stage synchroniser for a group of asynchronous inputs
module sync2 #(
    parameter W = 21
) (
    input wire clock,
    input wire rst_b,
    input wire ce,
    input wire [W-1:0] async_in,
    output reg [W-1:0] sync_out
);
    reg [W-1:0] meta_r;

    // First stage feeds only the second stage
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            meta_r <= {W{1'b0}};
            sync_out <= {W{1'b0}};
        end else if (ce) begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule // sync2

// file: verilog/deadline_timer.v
`timescale 1ns/1ps
// One-shot down counter; expired pulses load cycles after start
module deadline_timer (
    input wire clock,
    input wire rst_b,
    input wire ce,
    input wire start,
    input wire [27:0] load,
    output reg expired
);
    reg [27:0] cnt_r;
    reg run_r;

    // Restartable count, one-cycle expiry pulse
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cnt_r <= 28'h0;
            run_r <= 1'b0;
            expired <= 1'b0;
        end else if (ce) begin
            if (start) begin
                cnt_r <= load;
                run_r <= 1'b1;
                expired <= 1'b0;
            end else if (run_r) begin
                if (cnt_r <= 28'h1) begin
                    run_r <= 1'b0;
                    expired <= 1'b1;
                end else begin
                    cnt_r <= cnt_r - 28'h1;
                end
            end else begin
                expired <= 1'b0;
            end
        end
    end
endmodule // deadline_timer

// file: verilog/module_mgmt_status_timing.v
// What this block does
// - Fully functional within 2000 ms of start
// - Reset pin low for 2 us resets
// - Bus answers within 2000 ms of power-on
// - Clear data-not-ready, assert interrupt within 2000 ms
// - Fully functional within 2000 ms after reset rises
// - Interrupt goes low within 200 ms
// - Interrupt releases within 500 us of clearing read
// - Receive loss sets flag and interrupt quickly
// - Transmit fault sets flag and interrupt quickly
// - Other conditions set flag and interrupt quickly
// - Mask bit set inhibits interrupt within 100 ms
// - Mask bit cleared resumes interrupt within 100 ms
// - Select low enables bus answers within 100 us
// - Select high stops bus answers within 100 us
// - Power-down bit lowers power within 100 ms
// - Power-down cleared restores function within 300 ms
// - Fully functional once data-not-ready cleared
// - Clearing read deadlines start after stop
// - Control write deadlines start after stop
// - Flag bytes 3 to 21 read-only
// - Mask bytes 100 to 106 host-writable
`timescale 1ns/1ps
`include "mgmt_status_regs.vh"
module module_mgmt_status_timing #(
    parameter [27:0] INIT_CYCLES = `INIT_CYC
) (
    input wire clock,
    input wire rst_b,
    input wire ce,
    input wire module_reset_n_pin,
    input wire module_select_n,
    input wire low_power_request_pin,
    input wire scl_in,
    input wire sda_in,
    output reg sda_out,
    output reg sda_oe_n,
    input wire [3:0] rx_los,
    input wire [3:0] tx_fault,
    input wire [7:0] other_cond,
    output reg interrupt_out_n,
    output reg low_power_active,
    output reg fully_functional,
    output reg data_not_ready
);
    localparam [2:0] S_IDLE = 3'h0;
    localparam [2:0] S_ADDR = 3'h1;
    localparam [2:0] S_AACK = 3'h2;
    localparam [2:0] S_WR = 3'h3;
    localparam [2:0] S_WACK = 3'h4;
    localparam [2:0] S_RD = 3'h5;
    localparam [2:0] S_RACK = 3'h6;
    localparam [8:0] RST_MIN = `RST_MIN_CYC;

    // Address window test, used by read and write decoding
    function in_range;
        input [7:0] a;
        input [7:0] lo;
        input [7:0] hi;
        begin
            in_range = (a >= lo) && (a <= hi);
        end
    endfunction

    // Mask array index from a byte address
    function [2:0] mask_idx;
        input [7:0] a;
        reg [7:0] d;
        begin
            d = a - `A_MASK_FIRST;
            mask_idx = d[2:0];
        end
    endfunction

    wire rst_pin_s;
    wire sel_n_s;
    wire lp_s;
    wire scl_s;
    wire sda_s;
    wire [3:0] los_s;
    wire [3:0] fault_s;
    wire [7:0] other_s;
    wire init_done;

    reg [8:0] rl_cnt_r;
    reg boot_r;
    reg [2:0] state_r;
    reg [7:0] shift_r;
    reg [3:0] bit_r;
    reg [7:0] ptr_r;
    reg rw_r;
    reg first_r;
    reg ack_ok_r;
    reg scl_d_r;
    reg sda_d_r;
    reg init_int_r;
    reg pdown_r;
    reg [3:0] los_r;
    reg [3:0] fault_r;
    reg [7:0] other_r;
    reg [7:0] mask_r [0:`MASK_BYTES-1];
    reg [7:0] rd_data;
    integer i;

    // All pin-side inputs pass two flip-flops
    sync2 #(
        .W(21)
    ) u_sync (
        .clock(clock),
        .rst_b(rst_b),
        .ce(ce),
        .async_in({module_reset_n_pin, module_select_n, low_power_request_pin, scl_in,
            sda_in, rx_los, tx_fault, other_cond}),
        .sync_out({rst_pin_s, sel_n_s, lp_s, scl_s, sda_s, los_s, fault_s, other_s})
    );

    // Qualified reset pulse and restart of initialisation
    wire soft_rst = (rl_cnt_r == RST_MIN);
    wire init_go = boot_r | (soft_rst & rst_pin_s);

    deadline_timer u_init (
        .clock(clock),
        .rst_b(rst_b),
        .ce(ce),
        .start(init_go),
        .load(INIT_CYCLES),
        .expired(init_done)
    );

    // Bus edge and condition detection on sampled lines
    wire scl_rise = scl_s & ~scl_d_r;
    wire scl_fall = ~scl_s & scl_d_r;
    wire start_c = scl_s & scl_d_r & sda_d_r & ~sda_s;
    wire stop_c = scl_s & scl_d_r & ~sda_d_r & sda_s;
    wire bus_on = fully_functional & ~sel_n_s & ~soft_rst;
    wire load_tx = bus_on & scl_fall &
        (((state_r == S_AACK) & rw_r) | ((state_r == S_RACK) & ack_ok_r));
    wire wr_stb = bus_on & scl_fall & (state_r == S_WR) & (bit_r == `BYTE_BITS) & ~first_r;
    wire clr_los = load_tx & (ptr_r == `A_LOS_FLAG);
    wire clr_fault = load_tx & (ptr_r == `A_FAULT_FLAG);
    wire clr_other = load_tx & (ptr_r == `A_OTHER_FLAG);
    wire clr_init = load_tx & (ptr_r == `A_STATUS2);
    wire [7:0] m_los = mask_r[`MASK_LOS];
    wire [7:0] m_fault = mask_r[`MASK_FAULT];
    wire [7:0] m_other = mask_r[`MASK_OTHER];

    // Reset pin low-time counter, saturating at the minimum pulse
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rl_cnt_r <= 9'h0;
            boot_r <= 1'b1;
        end else if (ce) begin
            boot_r <= 1'b0;
            if (rst_pin_s) begin
                rl_cnt_r <= 9'h0;
            end else if (rl_cnt_r != RST_MIN) begin
                rl_cnt_r <= rl_cnt_r + 9'h1;
            end
        end
    end

    // Readiness, data-not-ready and its interrupt source
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            fully_functional <= 1'b0;
            data_not_ready <= 1'b1;
            init_int_r <= 1'b0;
        end else if (ce) begin
            if (soft_rst || init_go) begin
                fully_functional <= 1'b0;
                data_not_ready <= 1'b1;
                init_int_r <= 1'b0;
            end else if (init_done) begin
                fully_functional <= 1'b1;
                data_not_ready <= 1'b0;
                init_int_r <= 1'b1;
            end else if (clr_init) begin
                init_int_r <= 1'b0;
            end
        end
    end

    // Latched flags; a new condition wins over a clearing read
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            los_r <= 4'h0;
            fault_r <= 4'h0;
            other_r <= 8'h00;
        end else if (ce) begin
            if (soft_rst) begin
                los_r <= 4'h0;
                fault_r <= 4'h0;
                other_r <= 8'h00;
            end else if (fully_functional) begin
                los_r <= (los_r & ~{4{clr_los}}) | los_s;
                fault_r <= (fault_r & ~{4{clr_fault}}) | fault_s;
                other_r <= (other_r & ~{8{clr_other}}) | other_s;
            end
        end
    end

    // Host-writable masks and power-down control; flag bytes take no write
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pdown_r <= 1'b0;
            for (i = 0; i < `MASK_BYTES; i = i + 1) begin
                mask_r[i] <= 8'h00;
            end
        end else if (ce) begin
            if (soft_rst) begin
                pdown_r <= 1'b0;
                for (i = 0; i < `MASK_BYTES; i = i + 1) begin
                    mask_r[i] <= 8'h00;
                end
            end else if (wr_stb) begin
                if (ptr_r == `A_CTRL_PDOWN) begin
                    pdown_r <= shift_r[`PDOWN_BIT];
                end
                if (in_range(ptr_r, `A_MASK_FIRST, `A_MASK_LAST)) begin
                    mask_r[mask_idx(ptr_r)] <= shift_r;
                end
            end
        end
    end

    // Read data for the byte under the pointer
    always @* begin
        rd_data = 8'h00;
        if (ptr_r == `A_STATUS2) begin
            rd_data[`DNR_BIT] = data_not_ready;
        end else if (ptr_r == `A_LOS_FLAG) begin
            rd_data = {4'h0, los_r};
        end else if (ptr_r == `A_FAULT_FLAG) begin
            rd_data = {4'h0, fault_r};
        end else if (ptr_r == `A_OTHER_FLAG) begin
            rd_data = other_r;
        end else if (ptr_r == `A_CTRL_PDOWN) begin
            rd_data[`PDOWN_BIT] = pdown_r;
        end else if (in_range(ptr_r, `A_MASK_FIRST, `A_MASK_LAST)) begin
            rd_data = mask_r[mask_idx(ptr_r)];
        end
    end

    // Interrupt and power-level outputs
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            interrupt_out_n <= 1'b1;
            low_power_active <= 1'b0;
            sda_out <= 1'b0;
        end else if (ce) begin
            sda_out <= 1'b0;
            interrupt_out_n <= ~(init_int_r |
                (|(los_r & ~m_los[3:0])) |
                (|(fault_r & ~m_fault[3:0])) |
                (|(other_r & ~m_other)));
            low_power_active <= lp_s | pdown_r;
        end
    end

    // Two-wire bus slave: sample on SCL rise, change SDA on SCL fall
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= S_IDLE;
            shift_r <= 8'h00;
            bit_r <= 4'h0;
            ptr_r <= 8'h00;
            rw_r <= 1'b0;
            first_r <= 1'b0;
            ack_ok_r <= 1'b0;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
            sda_oe_n <= 1'b1;
        end else if (ce) begin
            scl_d_r <= scl_s;
            sda_d_r <= sda_s;
            if (!bus_on || stop_c) begin
                state_r <= S_IDLE;
                sda_oe_n <= 1'b1;
            end else if (start_c) begin
                state_r <= S_ADDR;
                bit_r <= 4'h0;
                sda_oe_n <= 1'b1;
            end else if (load_tx) begin
                shift_r <= rd_data;
                sda_oe_n <= rd_data[7];
                bit_r <= 4'h1;
                ptr_r <= ptr_r + 8'h01;
                state_r <= S_RD;
            end else begin
                case (state_r)
                    S_ADDR, S_WR: begin
                        if (scl_rise) begin
                            shift_r <= {shift_r[6:0], sda_s};
                            bit_r <= bit_r + 4'h1;
                        end else if (scl_fall && bit_r == `BYTE_BITS) begin
                            if (state_r == S_WR) begin
                                sda_oe_n <= 1'b0;
                                state_r <= S_WACK;
                                first_r <= 1'b0;
                                if (first_r) begin
                                    ptr_r <= shift_r;
                                end else begin
                                    ptr_r <= ptr_r + 8'h01;
                                end
                            end else if (shift_r[7:1] == `DEV_ADDR) begin
                                sda_oe_n <= 1'b0;
                                rw_r <= shift_r[0];
                                state_r <= S_AACK;
                            end else begin
                                state_r <= S_IDLE;
                            end
                        end
                    end
                    S_AACK, S_WACK: begin
                        if (scl_fall) begin
                            sda_oe_n <= 1'b1;
                            bit_r <= 4'h0;
                            state_r <= S_WR;
                            if (state_r == S_AACK) begin
                                first_r <= 1'b1;
                            end
                        end
                    end
                    S_RD: begin
                        if (scl_fall) begin
                            if (bit_r == `BYTE_BITS) begin
                                sda_oe_n <= 1'b1;
                                state_r <= S_RACK;
                            end else begin
                                sda_oe_n <= shift_r[6];
                                shift_r <= {shift_r[6:0], 1'b0};
                                bit_r <= bit_r + 4'h1;
                            end
                        end
                    end
                    S_RACK: begin
                        if (scl_rise) begin
                            ack_ok_r <= ~sda_s;
                        end else if (scl_fall) begin
                            state_r <= S_IDLE;
                        end
                    end
                    default: begin
                        state_r <= S_IDLE;
                    end
                endcase
            end
        end
    end
endmodule // module_mgmt_status_timing

// file: sim/module_mgmt_status_timing_props.sv
`timescale 1ns/1ps
// Port-level timing checks on the management supervisor
module module_mgmt_status_timing_props #(
    parameter [27:0] INIT_CYCLES = 28'd200
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic module_reset_n_pin,
    input wire logic module_select_n,
    input wire logic low_power_request_pin,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_n,
    input wire logic [3:0] rx_los,
    input wire logic [3:0] tx_fault,
    input wire logic [7:0] other_cond,
    input wire logic interrupt_out_n,
    input wire logic low_power_active,
    input wire logic fully_functional,
    input wire logic data_not_ready
);
    int wait_cnt;
    int low_cnt;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    // Cycles spent waiting for readiness, and cycles of reset pin held low
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            wait_cnt <= 0;
            low_cnt <= 0;
        end else begin
            wait_cnt <= (fully_functional || !module_reset_n_pin) ? 0 : wait_cnt + 1;
            low_cnt <= module_reset_n_pin ? 0 : (low_cnt < 300 ? low_cnt + 1 : low_cnt);
        end
    end
    property p_init_time;
        wait_cnt <= INIT_CYCLES + 10;
    endproperty
    a_init_time: assert property (p_init_time) else $error("readiness late");
    property p_soft_reset;
        low_cnt >= 260 |-> !fully_functional && data_not_ready;
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("long reset low ignored");
    property p_ready_flag;
        fully_functional |-> !data_not_ready;
    endproperty
    a_ready_flag: assert property (p_ready_flag) else $error("ready while not-ready set");
    property p_ready_int;
        $rose(fully_functional) |-> ##[0:2] !interrupt_out_n;
    endproperty
    a_ready_int: assert property (p_ready_int) else $error("no interrupt at readiness");
    property p_quiet_int;
        (!fully_functional) [*3] |-> interrupt_out_n;
    endproperty
    a_quiet_int: assert property (p_quiet_int) else $error("interrupt while not ready");
    property p_lp_pin;
        low_power_request_pin [*5] |-> low_power_active;
    endproperty
    a_lp_pin: assert property (p_lp_pin) else $error("low power pin not obeyed");
    property p_deselect;
        module_select_n [*6] |-> sda_oe_n;
    endproperty
    a_deselect: assert property (p_deselect) else $error("bus driven while deselected");
    property p_not_ready_bus;
        (!fully_functional) [*6] |-> sda_oe_n;
    endproperty
    a_not_ready_bus: assert property (p_not_ready_bus) else $error("bus driven early");
    // The device may only start pulling the data line while the bus clock is low
    property p_drive_zero;
        $fell(sda_oe_n) |-> !scl_in && !sda_out;
    endproperty
    a_drive_zero: assert property (p_drive_zero) else $error("data pulled with clock high");
    // Main scenarios reached
    c_ready: cover property ($rose(fully_functional));
    c_int: cover property ($fell(interrupt_out_n));
    c_ack: cover property (!sda_oe_n);
    c_lp: cover property ($rose(low_power_active));
endmodule // module_mgmt_status_timing_props

bind module_mgmt_status_timing module_mgmt_status_timing_props #(
    .INIT_CYCLES(INIT_CYCLES)
) module_mgmt_status_timing_props_inst (
    .clock(clock), .rst_b(rst_b), .ce(ce), .module_reset_n_pin(module_reset_n_pin),
    .module_select_n(module_select_n), .low_power_request_pin(low_power_request_pin),
    .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .rx_los(rx_los), .tx_fault(tx_fault), .other_cond(other_cond),
    .interrupt_out_n(interrupt_out_n), .low_power_active(low_power_active),
    .fully_functional(fully_functional), .data_not_ready(data_not_ready)
);

// file: sim/host_model.sv
`timescale 1ns/1ps
// Host side of the two-wire bus; bus clock period is ten system clocks
module host_model (
    input wire clock,
    input wire sda,
    output reg scl,
    output reg sda_h
);
    // Bus idles released, clock standing high
    initial begin
        scl = 1'b1;
        sda_h = 1'b1;
    end
    task tick(input integer n);
        repeat (n) @(posedge clock);
    endtask
    // One bit, data set while the clock is low, line read mid-high
    task put_bit(input reg b, output reg got);
        begin
            sda_h <= b;
            tick(3);
            scl <= 1'b1;
            tick(3);
            got = sda;
            tick(2);
            scl <= 1'b0;
            tick(2);
        end
    endtask
    // Byte MSB first, then the acknowledge slot
    task xfer(input [7:0] tx, input reg ack_in, output reg [7:0] rx, output reg ack);
        integer i;
        reg g;
        begin
            for (i = 7; i >= 0; i = i - 1) begin
                put_bit(tx[i], g);
                rx[i] = g;
            end
            put_bit(ack_in, ack);
        end
    endtask
    task start;
        begin
            sda_h <= 1'b1;
            scl <= 1'b1;
            tick(5);
            sda_h <= 1'b0;
            tick(5);
            scl <= 1'b0;
            tick(2);
        end
    endtask
    // Stop, then a falling bus clock edge is implied only by the next frame
    task stop;
        begin
            sda_h <= 1'b0;
            tick(5);
            scl <= 1'b1;
            tick(5);
            sda_h <= 1'b1;
            tick(5);
        end
    endtask
endmodule // host_model

// file: sim/module_mgmt_status_timing_tb.sv
`timescale 1ns/1ps
`include "mgmt_status_regs.vh"
module module_mgmt_status_timing_tb;
    reg clock;
    reg rst_b;
    reg module_reset_n_pin;
    reg module_select_n;
    reg low_power_request_pin;
    reg [3:0] rx_los;
    reg [3:0] tx_fault;
    reg [7:0] other_cond;
    wire scl;
    wire sda_h;
    wire sda;
    wire sda_out;
    wire sda_oe_n;
    wire interrupt_out_n;
    wire low_power_active;
    wire fully_functional;
    wire data_not_ready;
    integer mismatches;
    integer samples_checked;
    reg [7:0] rx;
    reg ack;
    // Open-drain data line with pull-up
    assign sda = sda_h & (sda_oe_n | sda_out);
    module_mgmt_status_timing #(.INIT_CYCLES(28'd200)) module_mgmt_status_timing_inst (
        .clock(clock), .rst_b(rst_b), .ce(1'b1), .module_reset_n_pin(module_reset_n_pin),
        .module_select_n(module_select_n), .low_power_request_pin(low_power_request_pin),
        .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .rx_los(rx_los), .tx_fault(tx_fault), .other_cond(other_cond),
        .interrupt_out_n(interrupt_out_n), .low_power_active(low_power_active),
        .fully_functional(fully_functional), .data_not_ready(data_not_ready));
    host_model host_model_inst (.clock(clock), .sda(sda), .scl(scl), .sda_h(sda_h));
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    task tick(input integer n);
        repeat (n) @(posedge clock);
    endtask
    task check(input [7:0] seen, input [7:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (seen !== exp) begin
                mismatches = mismatches + 1;
                $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
            end
        end
    endtask
    task results;
        begin
            $display("checked %0d mismatches %0d", samples_checked, mismatches);
            if (mismatches == 0 && samples_checked > 0) $display("TB: PASS");
            else $display("TB: FAIL");
            $finish;
        end
    endtask
    // Bounded wait: 0 interrupt, 1 ready, 2 low power
    task waitfor(input integer sel, input reg lvl, input integer n);
        integer i;
        reg v;
        begin
            for (i = 0; i < n; i = i + 1) begin
                @(posedge clock);
                v = (sel == 0) ? interrupt_out_n : (sel == 1) ? fully_functional : low_power_active;
                if (v === lvl) break;
            end
            check({7'h00, v}, {7'h00, lvl});
            if (v !== lvl) results;
        end
    endtask
    task wr(input [7:0] p, input [7:0] d);
        begin
            host_model_inst.start;
            host_model_inst.xfer({`DEV_ADDR, 1'b0}, 1'b1, rx, ack);
            check({7'h00, ack}, 8'h00);
            host_model_inst.xfer(p, 1'b1, rx, ack);
            host_model_inst.xfer(d, 1'b1, rx, ack);
            host_model_inst.stop;
        end
    endtask
    task rd(input [7:0] p, input [7:0] msk, input [7:0] exp);
        begin
            host_model_inst.start;
            host_model_inst.xfer({`DEV_ADDR, 1'b0}, 1'b1, rx, ack);
            host_model_inst.xfer(p, 1'b1, rx, ack);
            host_model_inst.stop;
            host_model_inst.start;
            host_model_inst.xfer({`DEV_ADDR, 1'b1}, 1'b1, rx, ack);
            check({7'h00, ack}, 8'h00);
            host_model_inst.xfer(8'hff, 1'b1, rx, ack);
            host_model_inst.stop;
            check(rx & msk, exp);
        end
    endtask
    task t_init;
        begin
            waitfor(1, 1'b1, 230);
            check({7'h00, data_not_ready}, 8'h00);
            waitfor(0, 1'b0, 5);
            rd(`A_STATUS2, 8'h01, 8'h00);
            waitfor(0, 1'b1, 20);
            $display("test init done");
        end
    endtask
    task t_los;
        begin
            rx_los <= 4'h1;
            tick(10);
            rx_los <= 4'h0;
            waitfor(0, 1'b0, 20);
            tick(30);
            check({7'h00, interrupt_out_n}, 8'h00);
            rd(`A_LOS_FLAG, 8'h0f, 8'h01);
            waitfor(0, 1'b1, 20);
            rd(`A_LOS_FLAG, 8'h0f, 8'h00);
            $display("test loss done");
        end
    endtask
    task t_flags;
        begin
            tx_fault <= 4'h8;
            other_cond <= 8'h80;
            tick(10);
            tx_fault <= 4'h0;
            other_cond <= 8'h00;
            waitfor(0, 1'b0, 20);
            wr(`A_FAULT_FLAG, 8'hff);
            rd(`A_FAULT_FLAG, 8'h0f, 8'h08);
            rd(`A_OTHER_FLAG, 8'hff, 8'h80);
            waitfor(0, 1'b1, 20);
            rd(`A_FAULT_FLAG, 8'h0f, 8'h00);
            $display("test flags done");
        end
    endtask
    task t_mask;
        begin
            wr(`A_MASK_FIRST, 8'h0f);
            rx_los <= 4'h2;
            tick(10);
            rx_los <= 4'h0;
            tick(30);
            check({7'h00, interrupt_out_n}, 8'h01);
            wr(`A_MASK_FIRST, 8'h00);
            waitfor(0, 1'b0, 20);
            rd(`A_LOS_FLAG, 8'h0f, 8'h02);
            waitfor(0, 1'b1, 20);
            $display("test mask done");
        end
    endtask
    task t_power;
        begin
            low_power_request_pin <= 1'b1;
            waitfor(2, 1'b1, 20);
            low_power_request_pin <= 1'b0;
            waitfor(2, 1'b0, 20);
            wr(`A_CTRL_PDOWN, 8'h02);
            waitfor(2, 1'b1, 20);
            wr(`A_CTRL_PDOWN, 8'h00);
            waitfor(2, 1'b0, 20);
            check({7'h00, fully_functional}, 8'h01);
            $display("test power done");
        end
    endtask
    task t_select;
        begin
            module_select_n <= 1'b1;
            tick(15);
            host_model_inst.start;
            host_model_inst.xfer({`DEV_ADDR, 1'b0}, 1'b1, rx, ack);
            host_model_inst.stop;
            check({7'h00, ack}, 8'h01);
            module_select_n <= 1'b0;
            tick(15);
            rd(`A_LOS_FLAG, 8'h0f, 8'h00);
            $display("test select done");
        end
    endtask
    task t_soft_reset;
        begin
            module_reset_n_pin <= 1'b0;
            tick(100);
            module_reset_n_pin <= 1'b1;
            tick(10);
            check({7'h00, fully_functional}, 8'h01);
            module_reset_n_pin <= 1'b0;
            tick(300);
            check({6'h00, fully_functional, data_not_ready}, 8'h01);
            module_reset_n_pin <= 1'b1;
            waitfor(1, 1'b1, 230);
            $display("test soft reset done");
        end
    endtask
    initial begin
        mismatches = 0;
        samples_checked = 0;
        rst_b = 1'b0;
        module_reset_n_pin = 1'b1;
        module_select_n = 1'b0;
        low_power_request_pin = 1'b0;
        rx_los = 4'h0;
        tx_fault = 4'h0;
        other_cond = 8'h00;
        tick(20);
        rst_b <= 1'b1;
        t_init;
        t_los;
        t_flags;
        t_mask;
        t_power;
        t_select;
        t_soft_reset;
        results;
    end
endmodule // module_mgmt_status_timing_tb
